/* src/ldo_regulator_control_regs.sv */
/*
  register bank and control decode for one low-dropout regulator channel.
  assumes an axi4-lite master on aclk, a sequencer that reads the slot plan and drives the
  power-state reset pulse, and low-power inputs arriving asynchronously on pins.
*/
// The AXI4-Lite register port is this design's own decision.
// How it works
// R1 - mode bit selects regulator or current switch
// R2 - disabled channel discharges unless float bit set
// R3 - all four channels off forces discharge
// R4 - voltage code: 50mV steps then 100mV steps
// R5 - fault raises interrupt and applies fault action
// R6 - startup slot: never, slot 1-14, on active
// R7 - shutdown slot: slot 1-14, else on off
// R8 - hibernate uses image voltage or disables output
// R9 - trigger field picks hibernate source
// R10 - image code encodes like output code
// R11 - power state machine restores mask defaults
// R12 - 16-bit read/write registers, unlisted bits zero
`timescale 1ns/1ps
`default_nettype none
module ldo_regulator_control_regs
  import ldo_regs_pkg::*;
#(
  parameter logic [15:0] CONTROL_RESET = ldo_regs_pkg::CONTROL_DEFAULT,
  parameter logic [15:0] SLOTS_RESET = ldo_regs_pkg::SLOTS_DEFAULT,
  parameter logic [15:0] LOW_POWER_RESET = ldo_regs_pkg::LOW_POWER_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ldo_regs_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ldo_regs_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic state_defaults_load,
  input wire logic channel_enabled,
  input wire logic [2:0] other_channels_enabled,
  input wire logic channel_fault,
  input wire logic low_power_input_1,
  input wire logic low_power_input_2,
  input wire logic low_power_input_3,
  output ldo_regs_pkg::analog_ctrl_s analog_ctrl,
  output ldo_regs_pkg::sequence_plan_s sequence_plan,
  output logic hibernating,
  output logic regulator_shutdown_req,
  output logic system_shutdown_req,
  output logic irq
);
  import ldo_regs_pkg::*;

  logic [15:0] control_q, slots_q, low_power_q, irq_status_q, irq_mask_q, hibernate_q;
  logic [2:0] lp_meta_q, lp_sync_q;
  logic fault_q;
  logic [ldo_regs_pkg::AW-1:0] awaddr_q;
  logic aw_held_q, w_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  function automatic logic [15:0] code_to_mv(input logic [4:0] code);
    logic [15:0] step;
    step = {12'h000, code[3:0]};
    // [R4] [R10] two linear segments joined at the top bit
    if (code[4]) begin
      code_to_mv = 16'(MV_BASE_HI + 16'(step * MV_STEP_HI));
    end else begin
      code_to_mv = 16'(MV_BASE_LO + 16'(step * MV_STEP_LO));
    end
  endfunction

  function automatic logic [7:0] word_index(input logic [ldo_regs_pkg::AW-1:0] a);
    word_index = a[9:2];
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be, input logic [15:0] m);
    logic [15:0] n;
    n = old;
    if (be[0]) begin
      n[7:0] = d[7:0];
    end
    if (be[1]) begin
      n[15:8] = d[15:8];
    end
    merge16 = n & m;
  endfunction

  // write path: address and data may arrive in either order
  wire aw_have = aw_held_q | s_axi_awvalid;
  wire w_have = w_held_q | s_axi_wvalid;
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
  wire [ldo_regs_pkg::AW-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  wire [7:0] wr_idx = word_index(wr_addr);
  wire wr_high_zero = wr_addr[ldo_regs_pkg::AW-1:10] == '0;
  wire wr_ctl = wr_fire & wr_high_zero & (wr_idx == IDX_CONTROL);
  wire wr_slt = wr_fire & wr_high_zero & (wr_idx == IDX_SLOTS);
  wire wr_lp = wr_fire & wr_high_zero & (wr_idx == IDX_LOW_POWER);
  wire wr_ist = wr_fire & wr_high_zero & (wr_idx == IDX_IRQ_STATUS);
  wire wr_imk = wr_fire & wr_high_zero & (wr_idx == IDX_IRQ_MASK);
  wire wr_hib = wr_fire & wr_high_zero & (wr_idx == IDX_HIBERNATE);
  wire wr_hit = wr_ctl | wr_slt | wr_lp | wr_ist | wr_imk | wr_hib;

  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;

  // read path
  wire rd_fire = s_axi_arvalid & ~s_axi_rvalid;
  wire [7:0] rd_idx = word_index(s_axi_araddr);
  wire rd_high_zero = s_axi_araddr[ldo_regs_pkg::AW-1:10] == '0;
  wire rd_ctl = rd_high_zero & (rd_idx == IDX_CONTROL);
  wire rd_slt = rd_high_zero & (rd_idx == IDX_SLOTS);
  wire rd_lp = rd_high_zero & (rd_idx == IDX_LOW_POWER);
  wire rd_ist = rd_high_zero & (rd_idx == IDX_IRQ_STATUS);
  wire rd_imk = rd_high_zero & (rd_idx == IDX_IRQ_MASK);
  wire rd_hib = rd_high_zero & (rd_idx == IDX_HIBERNATE);
  wire rd_hit = rd_ctl | rd_slt | rd_lp | rd_ist | rd_imk | rd_hib;
  // [R12] unlisted bits and the upper half read as zero
  wire [15:0] rd_word = ({16{rd_ctl}} & control_q) | ({16{rd_slt}} & slots_q) |
                        ({16{rd_lp}} & low_power_q) | ({16{rd_ist}} & irq_status_q) |
                        ({16{rd_imk}} & irq_mask_q) | ({16{rd_hib}} & hibernate_q);
  assign s_axi_arready = ~s_axi_rvalid;

  // field decode
  wire switch_mode_select = control_q[SWI_BIT];
  wire output_float_select = control_q[OPFLT_BIT];
  wire [4:0] output_voltage_code = control_q[VSEL_LO +: 5];
  wire [1:0] fault_action = slots_q[ERRACT_LO +: 2];
  wire [3:0] startup_slot = slots_q[ENSLOT_LO +: 4];
  wire [3:0] shutdown_slot = slots_q[SDSLOT_LO +: 4];
  wire [1:0] hibernate_behaviour = low_power_q[HIBMODE_LO +: 2];
  wire [1:0] hibernate_trigger_select = low_power_q[HIBTRIG_LO +: 2];
  wire [4:0] image_voltage_code = low_power_q[VSEL_LO +: 5];

  // [R9] source select; pins are used only after the second flop
  wire [3:0] hib_sources = {lp_sync_q, hibernate_q[0]};
  wire hib_active = hib_sources[hibernate_trigger_select];
  // [R8] reserved codes behave like image settings, the gentler choice
  wire hib_off = hib_active & (hibernate_behaviour == HIB_DISABLE);
  wire use_image = hib_active & (hibernate_behaviour != HIB_DISABLE);
  wire out_on = channel_enabled & ~hib_off;
  wire all_off = ~channel_enabled & (other_channels_enabled == 3'b000);
  wire [4:0] active_code = use_image ? image_voltage_code : output_voltage_code;

  // fault edge sets the sticky bit; same-cycle clear loses to the set
  wire fault_event = channel_fault & ~fault_q;
  wire [15:0] irq_clear = wr_ist ? (wr_data[15:0] & {16{wr_strb[0]}}) : 16'h0000;
  wire [15:0] irq_status_d = ((irq_status_q & ~irq_clear) | {15'h0000, fault_event}) &
                             IRQ_MASK_BITS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lp_meta_q <= 3'b000;
      lp_sync_q <= 3'b000;
      fault_q <= 1'b0;
    end else begin
      lp_meta_q <= {low_power_input_3, low_power_input_2, low_power_input_1};
      lp_sync_q <= lp_meta_q;
      fault_q <= channel_fault;
    end
  end

  // [R11] defaults come back on reset and on every power-state reload
  always_ff @(posedge aclk) begin
    if (!aresetn || state_defaults_load) begin
      control_q <= CONTROL_RESET & CONTROL_MASK;
      slots_q <= SLOTS_RESET & SLOTS_MASK;
      low_power_q <= LOW_POWER_RESET & LOW_POWER_MASK;
    end else begin
      // [R12] writes land on listed bits only
      if (wr_ctl) begin
        control_q <= merge16(control_q, wr_data, wr_strb, CONTROL_MASK);
      end
      if (wr_slt) begin
        slots_q <= merge16(slots_q, wr_data, wr_strb, SLOTS_MASK);
      end
      if (wr_lp) begin
        low_power_q <= merge16(low_power_q, wr_data, wr_strb, LOW_POWER_MASK);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= 16'h0000;
      irq_mask_q <= 16'h0000;
      hibernate_q <= 16'h0000;
    end else begin
      irq_status_q <= irq_status_d; // [R5]
      if (wr_imk) begin
        irq_mask_q <= merge16(irq_mask_q, wr_data, wr_strb, IRQ_MASK_BITS);
      end
      if (wr_hib) begin
        hibernate_q <= merge16(hibernate_q, wr_data, wr_strb, HIBERNATE_MASK);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_word};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // outputs to the analog channel and sequencer, all from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_ctrl <= '0;
      sequence_plan <= '0;
      hibernating <= 1'b0;
      regulator_shutdown_req <= 1'b0;
      system_shutdown_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      // [R1] in switch mode the voltage code is not applied
      analog_ctrl.regulate <= ~switch_mode_select;
      analog_ctrl.voltage_code <= switch_mode_select ? 5'h00 : active_code;
      analog_ctrl.voltage_mv <= switch_mode_select ? 16'h0000 : code_to_mv(active_code);
      // [R2] [R3] discharge when off unless floating, forced when all four are off
      analog_ctrl.discharge <= ~out_on & (~output_float_select | all_off);
      // [R6]
      sequence_plan.start_at_slot <= (startup_slot != SLOT_NEVER) &&
                                     (startup_slot != SLOT_ON_STATE);
      sequence_plan.start_on_active <= startup_slot == SLOT_ON_STATE;
      sequence_plan.start_slot <= startup_slot;
      // [R7]
      sequence_plan.stop_at_slot <= (shutdown_slot != SLOT_NEVER) &&
                                    (shutdown_slot != SLOT_ON_STATE);
      sequence_plan.stop_on_off <= (shutdown_slot == SLOT_NEVER) ||
                                   (shutdown_slot == SLOT_ON_STATE);
      sequence_plan.stop_slot <= shutdown_slot;
      hibernating <= hib_active;
      // [R5] one-cycle requests on the fault edge
      regulator_shutdown_req <= fault_event & (fault_action == ACT_SHUT_REG);
      system_shutdown_req <= fault_event & fault_action[1];
      irq <= |(irq_status_d & irq_mask_q);
    end
  end
endmodule
`default_nettype wire

/* src/ldo_regs_pkg.sv */
/*
  package for the regulator channel register bank: offsets, fields, defaults, codes.
  assumes a 32-bit axi4-lite slave with 16-bit registers in the low half of each word.
*/
`default_nettype none
package ldo_regs_pkg;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'hC8;
  localparam logic [7:0] IDX_SLOTS = 8'hC9;
  localparam logic [7:0] IDX_LOW_POWER = 8'hCA;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hCE;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hCF;
  localparam logic [7:0] IDX_HIBERNATE = 8'hD0;

  localparam int AW = 12;

  localparam logic [15:0] CONTROL_MASK = 16'h441F;
  localparam logic [15:0] SLOTS_MASK = 16'hFFC0;
  localparam logic [15:0] LOW_POWER_MASK = 16'h331F;
  localparam logic [15:0] IRQ_MASK_BITS = 16'h0001;
  localparam logic [15:0] HIBERNATE_MASK = 16'h0001;

  localparam int SWI_BIT = 14;
  localparam int OPFLT_BIT = 10;
  localparam int VSEL_LO = 0;
  localparam int ERRACT_LO = 14;
  localparam int ENSLOT_LO = 10;
  localparam int SDSLOT_LO = 6;
  localparam int HIBMODE_LO = 12;
  localparam int HIBTRIG_LO = 8;

  // defaults: mask-option values, overridable by top parameters
  localparam logic [15:0] CONTROL_DEFAULT = 16'h001C;
  localparam logic [15:0] SLOTS_DEFAULT = 16'h0000;
  localparam logic [15:0] LOW_POWER_DEFAULT = 16'h001C;

  localparam logic [3:0] SLOT_NEVER = 4'h0;
  localparam logic [3:0] SLOT_ON_STATE = 4'hF;
  localparam logic [1:0] HIB_USE_IMAGE = 2'h0;
  localparam logic [1:0] HIB_DISABLE = 2'h1;
  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_SHUT_REG = 2'h1;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam logic [15:0] MV_BASE_LO = 16'h0384;
  localparam logic [15:0] MV_STEP_LO = 16'h0032;
  localparam logic [15:0] MV_BASE_HI = 16'h0708;
  localparam logic [15:0] MV_STEP_HI = 16'h0064;

  typedef struct packed {
    logic start_at_slot;
    logic start_on_active;
    logic stop_at_slot;
    logic stop_on_off;
    logic [3:0] start_slot;
    logic [3:0] stop_slot;
  } sequence_plan_s;

  typedef struct packed {
    logic regulate;
    logic discharge;
    logic [4:0] voltage_code;
    logic [15:0] voltage_mv;
  } analog_ctrl_s;
endpackage
`default_nettype wire

/* verification/ldo_regs_props.sv */
/*
  checker for the regulator register bank: bus handshake and decode relations.
  assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module ldo_regs_props
  import ldo_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ldo_regs_pkg::analog_ctrl_s analog_ctrl,
  input wire logic regulator_shutdown_req,
  input wire logic system_shutdown_req
);
  logic [15:0] mv_exp;
  logic [3:0] c;
  assign c = analog_ctrl.voltage_code[3:0];
  // two linear segments with different step sizes
  assign mv_exp = analog_ctrl.voltage_code[4] ? 16'h0708 + 16'h0064 * c :
                  16'h0384 + 16'h0032 * c;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before it was taken");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half of read word not zero");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while a read is open");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while a response is open");
  a_switch_quiet: assert property (!analog_ctrl.regulate |-> analog_ctrl.voltage_mv == 16'h0000)
    else $error("switch mode still drives a voltage");
  a_volt_steps: assert property (analog_ctrl.regulate |-> analog_ctrl.voltage_mv == mv_exp)
    else $error("voltage does not match its code");
  a_shutdown_pulse: assert property (regulator_shutdown_req || system_shutdown_req |=>
    !regulator_shutdown_req && !system_shutdown_req)
    else $error("shutdown request longer than one cycle");
  a_one_action: assert property (!(regulator_shutdown_req && system_shutdown_req))
    else $error("both shutdown requests at once");
endmodule
`default_nettype wire

/* verification/tb.sv */
/*
  self-checking bench for the regulator register bank, driving every port itself.
  assumes the package, the design and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  import ldo_regs_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, state_defaults_load = 0, channel_enabled = 0;
  logic channel_fault = 0, low_power_input_1 = 0, low_power_input_2 = 0, low_power_input_3 = 0;
  logic [AW-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0, v4;
  logic [2:0] other_channels_enabled = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic hibernating, regulator_shutdown_req, system_shutdown_req, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  analog_ctrl_s analog_ctrl;
  sequence_plan_s sequence_plan;
  int miscompares = 0, cmp_count = 0, i, j, n_reg, n_sys;
  int sl[5] = '{0, 1, 7, 14, 15};
  logic [33:0] exp_q[$], em;
  logic [15:0] d, v;
  ldo_regulator_control_regs ldo_regulator_control_regs_inst (.*);
  always #12.5 aclk = ~aclk;
  // handshakes are judged half a cycle early, where nothing is changing
  always @(negedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      em = exp_q.pop_front();
      `CHK("bresp", em[33:32], s_axi_bresp);
    end
    if (s_axi_rvalid && s_axi_rready) begin
      em = exp_q.pop_front();
      `CHK("rdata", em, {s_axi_rresp, s_axi_rdata});
    end
  end
  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic guard(input int k);
    if (k >= 64) begin
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic wait_hi(ref logic s);
    int k;
    for (k = 0; k < 64; k++) begin
      @(negedge aclk);
      if (s === 1'b1) break;
    end
    guard(k);
    @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] dd, input logic [1:0] r = RESP_OKAY);
    logic both;
    @(posedge aclk);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, dd};
    s_axi_wstrb <= 4'h3;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    // the slave takes address and data on the same edge when idle
    #1 both = s_axi_awready && s_axi_wready;
    wait_hi(both);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    wait_hi(s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] dd, input logic [1:0] r = RESP_OKAY);
    @(posedge aclk);
    exp_q.push_back({r, 16'h0, dd});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    wait_hi(s_axi_arready);
    s_axi_arvalid <= 0;
    wait_hi(s_axi_rvalid);
    s_axi_rready <= 0;
  endtask
  initial begin
    void'($urandom(32'h94C5DF79));
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(12'h320, 16'h001C);
    rd(12'h324, 16'h0000);
    rd(12'h328, 16'h001C);
    rd(12'h3FC, 16'h0000, RESP_SLVERR);
    wr(12'h3FC, 16'hFFFF, RESP_SLVERR);
    for (i = 0; i < 3; i++) begin
      d = 16'($urandom);
      wr(12'(12'h320 + 4 * i), d);
      rd(12'(12'h320 + 4 * i), d & (i == 0 ? 16'h441F : i == 1 ? 16'hFFC0 : 16'h331F));
    end
    $display("test defaults and readback done");
    channel_enabled <= 1;
    for (i = 0; i < 33; i++) begin
      wr(12'h320, i == 32 ? 16'h4000 : 16'(i));
      repeat (2) @(negedge aclk);
      v = i[4] ? 16'h0708 + 16'h0064 * i[3:0] : 16'h0384 + 16'h0032 * i[3:0];
      `CHK("voltage_mv", i == 32 ? 16'h0000 : v, analog_ctrl.voltage_mv);
      `CHK("regulate", i != 32, analog_ctrl.regulate);
      `CHK("voltage_code", i == 32 ? 5'h00 : i[4:0], analog_ctrl.voltage_code);
    end
    for (i = 0; i < 8; i++) begin
      wr(12'h320, {5'h0, i[1], 10'h0});
      channel_enabled <= i[0];
      other_channels_enabled <= i[2] ? 3'h7 : 3'h0;
      repeat (2) @(negedge aclk);
      `CHK("discharge", !i[0] && (!i[1] || !i[2]), analog_ctrl.discharge);
    end
    $display("test voltage and discharge done");
    wr(12'h33C, 16'h0001);
    for (i = 0; i < 5; i++) begin
      wr(12'h324, {i[1:0], 14'h0});
      if (i == 4) wr(12'h33C, 16'h0000);
      n_reg = 0;
      n_sys = 0;
      channel_fault <= 1;
      repeat (6) begin
        @(negedge aclk);
        n_reg += regulator_shutdown_req;
        n_sys += system_shutdown_req;
      end
      `CHK("reg_shutdown", i == 1 ? 1 : 0, n_reg);
      `CHK("sys_shutdown", int'(i[1]), n_sys);
      `CHK("irq", i != 4, irq);
      rd(12'h338, 16'h0001);
      channel_fault <= 0;
      wr(12'h338, 16'h0001);
      @(negedge aclk);
      `CHK("irq_clear", 1'b0, irq);
    end
    for (i = 0; i < 5; i++) begin
      wr(12'h324, {2'h0, 4'(sl[i]), 4'(sl[i]), 6'h0});
      repeat (2) @(negedge aclk);
      v4 = {sl[i] inside {[1:14]}, sl[i] == 15, sl[i] inside {[1:14]}, sl[i] == 0 || sl[i] == 15};
      `CHK("plan", v4, sequence_plan[11:8]);
      if (sl[i] inside {[1:14]}) `CHK("slots", {4'(sl[i]), 4'(sl[i])}, sequence_plan[7:0]);
    end
    $display("test fault and slots done");
    wr(12'h320, 16'h0000);
    for (i = 0; i < 4; i++) begin
      wr(12'h328, {6'h0, 2'(i), 8'h03});
      for (j = 0; j < 2; j++) begin
        v4 = j ? 4'h1 << i : ~(4'h1 << i);
        wr(12'h340, {15'h0, v4[0]});
        {low_power_input_3, low_power_input_2, low_power_input_1} <= v4[3:1];
        repeat (4) @(negedge aclk);
        `CHK("hibernating", j[0], hibernating);
      end
      `CHK("image_mv", 16'h041A, analog_ctrl.voltage_mv);
    end
    wr(12'h328, 16'h1003);
    wr(12'h340, 16'h0001);
    repeat (2) @(negedge aclk);
    `CHK("hib_discharge", 1'b1, analog_ctrl.discharge);
    // a second reset in mid-run must bring the mask and hibernate bit back to zero
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(12'h33C, 16'h0000);
    rd(12'h340, 16'h0000);
    wr(12'h320, 16'h4400);
    @(posedge aclk);
    state_defaults_load <= 1;
    @(posedge aclk);
    state_defaults_load <= 0;
    rd(12'h320, 16'h001C);
    rd(12'h328, 16'h001C);
    $display("test hibernate and reload done");
    print_verdict();
  end
endmodule
bind ldo_regulator_control_regs ldo_regs_props ldo_regs_props_inst (.*);
`default_nettype wire
